// ### ldc_command_decode.sv
`timescale 1ns/1ns
// Behaviour
// - Hold a 16-bit control store, loaded with default fields at reset.
// - Unused control bits 0-3 and 12-14 read zero; fields take defaults.
// - Brightness is bits 4-9, 64 steps, default 100000.
// - Brightness all zero keeps every sink output off.
// - Bit 10 disables automatic refresh when one; default zero.
// - Refresh disabled: frame load fills second and third, blanks, clears count.
// - Refresh enabled: frame load fills second; third follows at count 65535.
// - Bit 11 enables the counter reset command; default zero.
// - Counter reset (12/13 edges) clears count, blanks, keeps third latch.
// - With bit 11 clear the counter reset command is ignored.
// - Bit 15 selects 16 word writes per frame when one, else 15.
// - Word write (0/1 edges) stores shift register at address counter slot.
// - Frame load (2/3 edges) also resets address counter to channel 15.
// - Config read (4/5 edges) loads control into shift register for output.
// - Config write (10/11 edges) just after unlock (14/15 edges) copies shift register into control store.
// - Serial clock rise shifts serial in at LSB; MSB drives serial out.
// - Reset clears shift register; outputs off until third latch loaded.
module ldc_command_decode (
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    input  wire logic                            serialClock,
    input  wire logic                            serialIn,
    input  wire logic                            loadStrobe,
    input  wire logic                            pwmClock,
    output logic                                 serialOut,
    output logic      [ldc_pkg::CHAN_N-1:0]      sinkOutput,
    output logic      [ldc_pkg::BRIGHT_W-1:0]    globalBrightness
);
    import ldc_pkg::*;

    function automatic logic [WORD_W-1:0] greyWord(
        input logic [STORE_W-1:0] vec,
        input int                 idx
    );
        greyWord = vec[idx*WORD_W +: WORD_W];
    endfunction

    // ==========================================================
    // Pin synchronisers and edge detection
    // ==========================================================
    logic [2:0] sclkSync_r;
    logic [1:0] sinSync_r;
    logic [2:0] latSync_r;
    logic [2:0] pwmSync_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkSync_r <= '0;
            sinSync_r  <= '0;
            latSync_r  <= '0;
            pwmSync_r  <= '0;
        end else begin
            sclkSync_r <= {sclkSync_r[1:0], serialClock};
            sinSync_r  <= {sinSync_r[0], serialIn};
            latSync_r  <= {latSync_r[1:0], loadStrobe};
            pwmSync_r  <= {pwmSync_r[1:0], pwmClock};
        end
    end

    wire sclkRise = sclkSync_r[1] && !sclkSync_r[2];
    wire latHigh  = latSync_r[1];
    wire latFall  = !latSync_r[1] && latSync_r[2];
    wire pwmRise  = pwmSync_r[1] && !pwmSync_r[2];
    wire sinBit   = sinSync_r[1];

    // ==========================================================
    // Registers
    // ==========================================================
    logic [WORD_W-1:0]  shift_r;
    logic [WORD_W-1:0]  ctrl_r;
    logic [EDGE_W-1:0]  edgeCnt_r;
    logic               unlock_r;
    logic [ADDR_W-1:0]  addr_r;
    logic [WORD_W-1:0]  cmdData_r;
    logic [WORD_W-1:0]  pwmCount_r;
    logic [STORE_W-1:0] second_r;
    logic [STORE_W-1:0] third_r;
    logic               loaded_r;
    logic               forceOff_r;
    logic [CHAN_N-1:0]  sink_r;
    logic               serialOut_r;
    ldc_state_t         state_r;
    ldc_state_t         state_nxt;

    // ==========================================================
    // Decode
    // ==========================================================
    wire [EDGE_W-2:0] cmdCode     = edgeCnt_r[EDGE_W-1:1];
    wire              inIdle      = (state_r == ST_IDLE);
    wire              take        = latFall && inIdle;
    wire              isWordWrite = take && (cmdCode == CMD_WORD_WRITE);
    wire              isFrameLoad = take && (cmdCode == CMD_FRAME_LOAD);
    wire              isCfgRead   = take && (cmdCode == CMD_CONFIG_READ);
    wire              isCfgWrite  = take && (cmdCode == CMD_CONFIG_WRITE);
    wire              isCntReset  = take && (cmdCode == CMD_COUNTER_RST);
    wire              isUnlock    = take && (cmdCode == CMD_UNLOCK);
    wire              refreshDis  = ctrl_r[REFRESH_DIS_BIT];
    wire              tmrRstEn    = ctrl_r[TMR_RST_EN_BIT];
    wire              loadMode16  = ctrl_r[LOAD_MODE_BIT];
    wire              cfgAccept   = isCfgWrite && unlock_r;
    wire              cntResetGo  = isCntReset && tmrRstEn;
    wire              frameCopy   = (state_r == ST_COPY);
    wire              copyToThird = frameCopy && refreshDis;
    wire              autoRefresh = pwmRise && !refreshDis &&
                                    (pwmCount_r == COUNT_MAX);

    // ==========================================================
    // Word FIFO in front of the first latch
    // ==========================================================
    // The FIFO decouples command timing from latch writes; a frame
    // copy waits until it drains so no word is lost or reordered.
    logic              fifoInReady;
    logic [FIFO_W-1:0] fifoOutData;
    logic              fifoOutValid;
    logic [STORE_W-1:0] firstWords;
    wire               fifoInValid = (state_r == ST_PUSH);
    wire               drainReady  = !frameCopy;
    wire               pushDone    = fifoInValid && fifoInReady;

    ldc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .inData   ({addr_r, cmdData_r}),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (drainReady)
    );

    ldc_grey_store u_first (
        .clk      (clk),
        .arst_n   (arst_n),
        .wrEn     (fifoOutValid && drainReady),
        .wrAddr   (fifoOutData[FIFO_W-1:WORD_W]),
        .wrData   (fifoOutData[WORD_W-1:0]),
        .allWords (firstWords)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    logic frameAfter_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (isWordWrite) begin
                    state_nxt = ST_PUSH;
                end else if (isFrameLoad) begin
                    // 15-write mode captures the last word here.
                    state_nxt = loadMode16 ? ST_DRAIN : ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (pushDone) begin
                    state_nxt = frameAfter_r ? ST_DRAIN : ST_IDLE;
                end
            end
            ST_DRAIN: begin
                if (!fifoOutValid) begin
                    state_nxt = ST_COPY;
                end
            end
            ST_COPY: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r      <= ST_IDLE;
            frameAfter_r <= 1'b0;
            cmdData_r    <= '0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                frameAfter_r <= isFrameLoad;
                cmdData_r    <= shift_r;
            end
        end
    end

    // ==========================================================
    // Serial front end
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r   <= '0;
            edgeCnt_r <= '0;
        end else begin
            if (isCfgRead) begin
                shift_r <= ctrl_r;
            end else if (sclkRise) begin
                shift_r <= {shift_r[WORD_W-2:0], sinBit};
            end
            if (latFall) begin
                edgeCnt_r <= '0;
            end else if (latHigh && sclkRise && edgeCnt_r != EDGE_MAX) begin
                edgeCnt_r <= edgeCnt_r + 1'b1;
            end
        end
    end

    // ==========================================================
    // Control store and unlock
    // ==========================================================
    // Unassigned edge counts fall through every decode term above,
    // so they only cancel the unlock.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r   <= CTRL_RESET;
            unlock_r <= 1'b0;
        end else begin
            if (cfgAccept) begin
                ctrl_r <= cmdDataMask(shift_r);
            end
            if (take) begin
                unlock_r <= isUnlock;
            end
        end
    end

    function automatic logic [WORD_W-1:0] cmdDataMask(
        input logic [WORD_W-1:0] v
    );
        cmdDataMask = v & CTRL_MASK;
    endfunction

    // ==========================================================
    // Address counter
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= ADDR_FIRST;
        end else if (frameCopy) begin
            addr_r <= ADDR_FIRST;
        end else if (pushDone) begin
            addr_r <= addr_r - 1'b1;
        end
    end

    // ==========================================================
    // Second and third latches, PWM counter
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            second_r   <= '0;
            third_r    <= '0;
            loaded_r   <= 1'b0;
            pwmCount_r <= '0;
            forceOff_r <= 1'b1;
        end else begin
            if (frameCopy) begin
                second_r <= firstWords;
            end
            if (copyToThird) begin
                third_r  <= firstWords;
                loaded_r <= 1'b1;
            end else if (autoRefresh) begin
                third_r  <= second_r;
                loaded_r <= 1'b1;
            end
            if (copyToThird || cntResetGo) begin
                pwmCount_r <= '0;
                forceOff_r <= 1'b1;
            end else if (pwmRise) begin
                pwmCount_r <= pwmCount_r + 1'b1;
                forceOff_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sink outputs
    // ==========================================================
    // Only the on/off decision is made here; current scaling by the
    // brightness field is left to the analog stage.
    wire brightOn = (ctrl_r[BRIGHT_LSB +: BRIGHT_W] != '0);
    logic [CHAN_N-1:0] sinkOn;

    always_comb begin
        for (int i = 0; i < CHAN_N; i++) begin
            sinkOn[i] = brightOn && loaded_r && !forceOff_r &&
                        (pwmCount_r < greyWord(third_r, i));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sink_r      <= '0;
            serialOut_r <= 1'b0;
        end else begin
            sink_r      <= sinkOn;
            serialOut_r <= shift_r[WORD_W-1];
        end
    end

    assign sinkOutput       = sink_r;
    assign serialOut        = serialOut_r;
    assign globalBrightness = ctrl_r[BRIGHT_LSB +: BRIGHT_W];
endmodule

// ### ldc_command_decode_assertions.sv
`timescale 1ns/1ns
module ldc_command_decode_assertions (
    input wire logic                          clk,
    input wire logic                          arst_n,
    input wire logic                          serialClock,
    input wire logic                          serialIn,
    input wire logic                          loadStrobe,
    input wire logic                          pwmClock,
    input wire logic                          serialOut,
    input wire logic [ldc_pkg::CHAN_N-1:0]    sinkOutput,
    input wire logic [ldc_pkg::BRIGHT_W-1:0]  globalBrightness
);
    import ldc_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Quiet counters
    // ==========================================================
    // Pins pass a synchroniser, so outputs lag them by several clocks.
    logic [4:0] linkQuiet_r;
    logic [4:0] pwmQuiet_r;
    logic       sclkPrev_r;
    logic       strbPrev_r;
    logic       pwmPrev_r;
    logic       seenFall_r;
    logic       seenLink_r;
    wire        strbMove = loadStrobe != strbPrev_r;
    wire        linkMove = strbMove || (serialClock != sclkPrev_r);
    wire        pwmMove  = strbMove || (pwmClock != pwmPrev_r);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            linkQuiet_r <= 5'h00;
            pwmQuiet_r  <= 5'h00;
            sclkPrev_r  <= 1'b0;
            strbPrev_r  <= 1'b0;
            pwmPrev_r   <= 1'b0;
            seenFall_r  <= 1'b0;
            seenLink_r  <= 1'b0;
        end else begin
            sclkPrev_r  <= serialClock;
            strbPrev_r  <= loadStrobe;
            pwmPrev_r   <= pwmClock;
            linkQuiet_r <= linkMove ? 5'h00 :
                           linkQuiet_r + 5'(linkQuiet_r != 5'h1F);
            pwmQuiet_r  <= pwmMove ? 5'h00 :
                           pwmQuiet_r + 5'(pwmQuiet_r != 5'h1F);
            seenFall_r  <= seenFall_r || (strbPrev_r && !loadStrobe);
            seenLink_r  <= seenLink_r || linkMove;
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    a_serial_out_hold_quiet: assert property (
        linkQuiet_r >= 5'h14 |-> $stable(serialOut))
        else $error("serial out moved with the link quiet");
    a_sink_hold_quiet: assert property (
        pwmQuiet_r >= 5'h14 |-> $stable(sinkOutput))
        else $error("sink outputs moved with no cause");
    a_bright_zero_off: assert property (
        (globalBrightness == 6'h00)[*3] |-> sinkOutput == 16'h0000)
        else $error("output on with zero brightness");
    a_bright_strobe_low: assert property (
        $changed(globalBrightness) |-> !loadStrobe && !$past(loadStrobe))
        else $error("brightness changed before strobe fall");
    a_bright_wait_fall: assert property (
        loadStrobe[*8] |-> $stable(globalBrightness))
        else $error("brightness changed while strobe high");
    a_bright_single_update: assert property (
        $changed(globalBrightness) |=> $stable(globalBrightness)[*8])
        else $error("brightness updated twice for one command");
    a_off_until_load: assert property (
        !seenFall_r |-> sinkOutput == 16'h0000)
        else $error("output on before any frame load");
    a_serial_out_clear_reset: assert property (
        !seenLink_r |-> !serialOut)
        else $error("serial out not cleared after reset");

    c_bright_change: cover property ($changed(globalBrightness));
    c_pattern_even: cover property (sinkOutput == 16'h5555);
    c_pattern_odd: cover property (sinkOutput == 16'hAAAA);
    c_serial_out_rise: cover property ($rose(serialOut));
endmodule

// ### ldc_command_decode_bench.sv
`timescale 1ns/1ns
module ldc_command_decode_bench;
    import ldc_pkg::*;
    logic                clk      = 1'b0;
    logic                arst_n   = 1'b0;
    logic                pwmClock = 1'b0;
    wire                 serialClock;
    wire                 serialIn;
    wire                 loadStrobe;
    wire                 serialOut;
    wire  [CHAN_N-1:0]   sinkOutput;
    wire  [BRIGHT_W-1:0] globalBrightness;
    int                  errors;
    int                  samples_checked;
    int                  cycles;
    logic [15:0]         rd;

    always #2 clk = ~clk;

    ldc_command_decode u_ldc_command_decode (
        .clk(clk), .arst_n(arst_n), .serialClock(serialClock),
        .serialIn(serialIn), .loadStrobe(loadStrobe), .pwmClock(pwmClock),
        .serialOut(serialOut), .sinkOutput(sinkOutput),
        .globalBrightness(globalBrightness));

    ldc_host_model u_ldc_host_model (
        .clk(clk), .serialOut(serialOut), .serialClock(serialClock),
        .serialIn(serialIn), .loadStrobe(loadStrobe));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic end_sim();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Optional unlock with u edges, then a command of c edges carrying w.
    task automatic cfg(input logic [15:0] w, input int u, input int c);
        if (u != 0)
            u_ldc_host_model.xfer(16'h0000, u);
        u_ldc_host_model.xfer(w, c);
    endtask

    task automatic pwm(input int n);
        repeat (n) begin
            pwmClock <= 1'b1;
            repeat (4) @(posedge clk);
            pwmClock <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // Full-on words on channels whose parity bit equals odd, zero elsewhere.
    task automatic frame(input logic odd, input int n, input int lastCnt);
        logic [3:0]  ch;
        logic [15:0] val;
        for (int k = 0; k < 16; k++) begin
            ch  = 4'(15 - k);
            val = (ch[0] == odd) ? 16'hFFFF : 16'h0000;
            if (k < n)
                u_ldc_host_model.xfer(val, k % 2);
            else
                u_ldc_host_model.xfer(val, lastCnt);
        end
        if (n == 16)
            u_ldc_host_model.xfer(16'h0000, lastCnt);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            end_sim();
        end
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("bright", 16'h0020, {10'h000, globalBrightness});
        chk("sink", 16'h0000, sinkOutput);
        chk("serial_out", 16'h0000, {15'h0000, serialOut});
        u_ldc_host_model.xfer(16'h0000, 4);
        u_ldc_host_model.read_word(rd);
        chk("ctrl", 16'h0200, rd);
        cfg(16'h03F0, 0, 10);
        chk("bright", 16'h0020, {10'h000, globalBrightness});
        for (int c = 6; c < 10; c++) begin
            cfg(16'h0000, 15, c);
            cfg(16'h03F0, 0, 11);
            chk("bright", 16'h0020, {10'h000, globalBrightness});
        end
        cfg(16'hFFFF, 14, 10);
        chk("bright", 16'h003F, {10'h000, globalBrightness});
        u_ldc_host_model.xfer(16'h0000, 5);
        u_ldc_host_model.read_word(rd);
        chk("ctrl", 16'h8FF0, rd);
        cfg(16'h0C00, 15, 11);
        chk("bright", 16'h0000, {10'h000, globalBrightness});
        frame(1'b0, 15, 2);
        pwm(3);
        chk("sink", 16'h0000, sinkOutput);
        cfg(16'h0FF0, 14, 10);
        pwm(2);
        chk("sink", 16'h5555, sinkOutput);
        u_ldc_host_model.xfer(16'h0000, 12);
        chk("sink", 16'h0000, sinkOutput);
        pwm(2);
        chk("sink", 16'h5555, sinkOutput);
        cfg(16'h87F0, 14, 11);
        u_ldc_host_model.xfer(16'h0000, 13);
        chk("sink", 16'h5555, sinkOutput);
        frame(1'b1, 16, 3);
        pwm(2);
        chk("sink", 16'hAAAA, sinkOutput);
        // With refresh enabled a frame load must not touch the shown frame.
        cfg(16'h83F0, 14, 10);
        chk("bright", 16'h003F, {10'h000, globalBrightness});
        frame(1'b0, 16, 2);
        chk("sink", 16'hAAAA, sinkOutput);
        pwm(2);
        chk("sink", 16'hAAAA, sinkOutput);
        end_sim();
    end
endmodule

bind ldc_command_decode ldc_command_decode_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .serialClock(serialClock),
    .serialIn(serialIn), .loadStrobe(loadStrobe), .pwmClock(pwmClock),
    .serialOut(serialOut), .sinkOutput(sinkOutput),
    .globalBrightness(globalBrightness));

// ### ldc_fifo.sv
`timescale 1ns/1ns
module ldc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic [PW:0]      count_r;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    // ==========================================================
    // Flags
    // ==========================================================
    assign inReady  = (count_r != (PW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem[rdPtr_r];

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
        end
    end
endmodule

// ### ldc_grey_store.sv
`timescale 1ns/1ns
module ldc_grey_store (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          wrEn,
    input  wire logic [ldc_pkg::ADDR_W-1:0]    wrAddr,
    input  wire logic [ldc_pkg::WORD_W-1:0]    wrData,
    output logic      [ldc_pkg::STORE_W-1:0]   allWords
);
    import ldc_pkg::*;

    // ==========================================================
    // First grey-level latch, all words visible at once.
    // ==========================================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            allWords <= '0;
        end else if (wrEn) begin
            allWords[wrAddr*WORD_W +: WORD_W] <= wrData;
        end
    end
endmodule

// ### ldc_host_model.sv
`timescale 1ns/1ns
module ldc_host_model (
    input  wire logic clk,
    input  wire logic serialOut,
    output logic      serialClock,
    output logic      serialIn,
    output logic      loadStrobe
);
    // The serial clock stands low outside transfers.
    initial begin
        serialClock = 1'b0;
        serialIn    = 1'b0;
        loadStrobe  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse();
        serialClock <= 1'b1;
        wait_clk(10);
        serialClock <= 1'b0;
        wait_clk(10);
    endtask

    // Sends w MSB first; the last n edges come with the strobe high.
    task automatic xfer(input logic [15:0] w, input int n);
        int total;
        total = (n > 16) ? n : 16;
        wait_clk(1);
        for (int k = 0; k < total; k++) begin
            if (k == total - n) begin
                loadStrobe <= 1'b1;
                wait_clk(10);
            end
            serialIn <= (total - 1 - k < 16) ? w[total-1-k] : 1'b0;
            wait_clk(10);
            pulse();
        end
        if (n == 0) begin
            loadStrobe <= 1'b1;
            wait_clk(10);
        end
        loadStrobe <= 1'b0;
        wait_clk(30);
    endtask

    // Samples serial out before each rising edge, MSB first.
    task automatic read_word(output logic [15:0] w);
        for (int k = 0; k < 16; k++) begin
            w[15-k] = serialOut;
            serialIn <= 1'b0;
            pulse();
        end
    endtask
endmodule

// ### ldc_pkg.sv
package ldc_pkg;
    // ==========================================================
    // Widths
    // ==========================================================
    localparam int WORD_W     = 16;
    localparam int CHAN_N     = 16;
    localparam int ADDR_W     = 4;
    localparam int EDGE_W     = 5;
    localparam int BRIGHT_W   = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W     = ADDR_W + WORD_W;
    localparam int STORE_W    = CHAN_N * WORD_W;

    // ==========================================================
    // Control store layout and reset value
    // ==========================================================
    localparam int BRIGHT_LSB      = 4;
    localparam int REFRESH_DIS_BIT = 10;
    localparam int TMR_RST_EN_BIT  = 11;
    localparam int LOAD_MODE_BIT   = 15;
    localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0200;
    localparam logic [WORD_W-1:0] CTRL_MASK  = 16'h8FF0;

    // ==========================================================
    // Command codes: strobe-high edge count divided by two
    // ==========================================================
    localparam logic [EDGE_W-2:0] CMD_WORD_WRITE   = 4'h0;
    localparam logic [EDGE_W-2:0] CMD_FRAME_LOAD   = 4'h1;
    localparam logic [EDGE_W-2:0] CMD_CONFIG_READ  = 4'h2;
    localparam logic [EDGE_W-2:0] CMD_CONFIG_WRITE = 4'h5;
    localparam logic [EDGE_W-2:0] CMD_COUNTER_RST  = 4'h6;
    localparam logic [EDGE_W-2:0] CMD_UNLOCK       = 4'h7;

    localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'hF;
    localparam logic [WORD_W-1:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [EDGE_W-1:0] EDGE_MAX   = 5'h1F;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PUSH  = 4'b0010,
        ST_DRAIN = 4'b0100,
        ST_COPY  = 4'b1000
    } ldc_state_t;
endpackage
